// *** rtl/pdt_params.svh ***
/*
  offsets, field positions, reset values and widths of the dead-time output path.
  assumes inclusion by bare name from the package and the design module.
*/
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PDT_OFS_DTCTRL   8'h00
`define PDT_OFS_TCMD     8'h04
`define PDT_OFS_MODCTRL  8'h08
`define PDT_OFS_PSL      8'h0C
`define PDT_OFS_TRAPEN   8'h10
`define PDT_OFS_COMPARE_STATUS_REG  8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define PDT_DT_LEN_LSB   0
`define PDT_DT_EN_LSB    8
`define PDT_DT_BUSY_LSB  16
`define PDT_CMD_DEAD_TIME_RESET_CMD    0
`define PDT_CMD_STE_SET  1
`define PDT_CMD_STE_CLR  2
`define PDT_CMD_STE_RD   3
`define PDT_MOD_T12_LSB  0
`define PDT_MOD_MCM      7
`define PDT_MOD_T13_LSB  8
`define PDT_CMP_ST_LSB   0
`define PDT_CMP_SEL_LSB  8

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define PDT_ADDR_W       8
`define PDT_DT_W         8
`define PDT_NCH          3
`define PDT_NOUT         6
`define PDT_RST_DT_LEN   8'h00
`define PDT_RST_DT_EN    3'h0
`define PDT_RST_ACT_SEL  6'h2A
`define PDT_RST_PSL      6'h00
`define PDT_RST_MOD      6'h00
`define PDT_RST_TRAPEN   6'h00

`endif

// *** rtl/pdt_pkg.sv ***
/*
  types of the dead-time output path: timer status carrier and the module state.
  assumes pdt_params.svh sits beside it on the include path.
*/
`include "pdt_params.svh"

package pdt_pkg;

  // ----------------------------------------
  // timer status from the main timer
  // ----------------------------------------
  typedef struct packed {
    logic run;
    logic count_down;
    logic period_match;
    logic one_match;
  } pdt_timer_s;

  // ----------------------------------------
  // whole state of the output path
  // ----------------------------------------
  typedef struct packed {
    logic [`PDT_DT_W-1:0]                   dead_time_length;
    logic [`PDT_NCH-1:0]                    dead_time_enable;
    logic [`PDT_NCH-1:0]                    st_prev;
    logic [`PDT_NCH-1:0][`PDT_DT_W-1:0]     dt_cnt;
    logic [`PDT_NOUT-1:0]                   main_timer_mod_enable;
    logic [`PDT_NOUT-1:0]                   aux_timer_mod_enable;
    logic                                   multichannel_mod_enable;
    logic [`PDT_NOUT-1:0]                   trap_enable;
    logic [`PDT_NOUT-1:0]                   psl_shadow;
    logic [`PDT_NOUT-1:0]                   psl_work;
    logic [`PDT_NOUT-1:0]                   act_before;
    logic                                   shadow_transfer_enable;
    logic [`PDT_NCH-1:0]                    primary_output;
    logic [`PDT_NCH-1:0]                    complementary_output;
    logic                                   pready;
    logic                                   pslverr;
    logic [31:0]                            prdata;
  } pdt_state_s;

endpackage

// *** rtl/pdt_output_path.sv ***
/*
  compare-mode output path of a three-channel pwm unit: dead time, state selection,
  output modulation, passive level selection, plus the apb register slave.
  assumes channel state bits, timer status, aux compare signal, pattern bits and
  trap state come from logic on pclk; pins go to external power switch drivers.
*/
// Implementation choices: the register addresses and the APB slave port.
`include "pdt_params.svh"

// What this block does
// - delay passive-to-active edges only
// - state change starts dead-time counter on pclk
// - one dead-time length for all channels
// - reset command idles all dead-time counters
// - per-channel enable; disabled counter never delays
// - state changes ignored while dead time runs
// - direct and inverted copies masked by counter
// - direct and inverted never active together
// - per-output select: active before or after
// - main compare signal gated per output
// - aux compare signal gated per output
// - pattern bits gated by one shared enable
// - active only when all enabled inputs active
// - nothing enabled gives passive
// - trap forces trap-enabled outputs passive
// - pin is passive level, inverted when active
// - passive levels shadowed, copied on transfer
// - reads give working levels, writes shadow
// - identical structure for all three channels
// - transfer when stopped or on matches
module pdt_output_path (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`PDT_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // compare sources
  input  wire logic [`PDT_NCH-1:0]        channel_state_bit,
  input  wire pdt_pkg::pdt_timer_s        timer,
  input  wire logic                       aux_compare_signal,
  input  wire logic [`PDT_NOUT-1:0]       multichannel_pattern_bit,
  input  wire logic                       trap_state,
  // output pins
  output logic      [`PDT_NCH-1:0]        primary_output,
  output logic      [`PDT_NCH-1:0]        complementary_output
);

  // ----------------------------------------
  // state and combinational helpers
  // ----------------------------------------
  pdt_pkg::pdt_state_s      s;
  pdt_pkg::pdt_state_s      next_s;
  logic [`PDT_NCH-1:0]      dt_start;
  logic [`PDT_NCH-1:0]      dt_busy;
  logic [`PDT_NCH-1:0]      dir_sig;
  logic [`PDT_NCH-1:0]      inv_sig;
  logic [`PDT_NOUT-1:0]     mod_act;
  logic [`PDT_NOUT-1:0]     cmp_sig;
  logic                     main_shadow_transfer;
  logic                     wr_acc;
  logic                     dead_time_reset_cmd;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [`PDT_NOUT-1:0] any_en;
    logic                 rd_hit;
    logic [31:0]          rd_val;
    cmp_sig = '0;
    any_en  = '0;
    rd_hit  = 1'b0;
    rd_val  = 32'h0000_0000;
    next_s  = s;

    wr_acc = psel & penable & s.pready & pwrite;
    dead_time_reset_cmd = wr_acc && (paddr == `PDT_OFS_TCMD) && pwdata[`PDT_CMD_DEAD_TIME_RESET_CMD];

    main_shadow_transfer = !timer.run
      || (s.shadow_transfer_enable && timer.period_match && !timer.count_down)
      || (s.shadow_transfer_enable && timer.one_match && timer.count_down);

    // dead-time stage, one per channel
    for (int c = 0; c < `PDT_NCH; c++) begin
      // a zero length means no dead time at all, not a wrap to 255
      dt_start[c] = s.dead_time_enable[c] && (channel_state_bit[c] != s.st_prev[c])
        && (s.dt_cnt[c] == '0) && (s.dead_time_length != '0);
      dt_busy[c] = s.dead_time_enable[c] && (dt_start[c] || (s.dt_cnt[c] != '0));
      dir_sig[c] = channel_state_bit[c] & ~dt_busy[c];
      inv_sig[c] = ~channel_state_bit[c] & ~dt_busy[c];
      next_s.st_prev[c] = channel_state_bit[c];
      if (dead_time_reset_cmd || !s.dead_time_enable[c]) begin
        next_s.dt_cnt[c] = '0;
      end else if (dt_start[c]) begin
        next_s.dt_cnt[c] = s.dead_time_length - 8'h01;
      end else if (s.dt_cnt[c] != '0) begin
        next_s.dt_cnt[c] = s.dt_cnt[c] - 8'h01;
      end
      // state selection: even index primary, odd complementary
      cmp_sig[2*c]   = s.act_before[2*c]   ? inv_sig[c] : dir_sig[c];
      cmp_sig[2*c+1] = s.act_before[2*c+1] ? inv_sig[c] : dir_sig[c];
    end

    // modulation and level selection, one per output
    for (int y = 0; y < `PDT_NOUT; y++) begin
      any_en[y] = s.main_timer_mod_enable[y] | s.aux_timer_mod_enable[y] | s.multichannel_mod_enable;
      mod_act[y] = any_en[y]
        && (!s.main_timer_mod_enable[y] || cmp_sig[y])
        && (!s.aux_timer_mod_enable[y] || aux_compare_signal)
        && (!s.multichannel_mod_enable || multichannel_pattern_bit[y])
        && !(trap_state && s.trap_enable[y]);
    end
    for (int c = 0; c < `PDT_NCH; c++) begin
      next_s.primary_output[c]       = s.psl_work[2*c] ^ mod_act[2*c];
      next_s.complementary_output[c] = s.psl_work[2*c+1] ^ mod_act[2*c+1];
    end

    // working passive levels only move on the shadow transfer
    if (main_shadow_transfer) begin
      next_s.psl_work = s.psl_shadow;
      next_s.shadow_transfer_enable = 1'b0;
    end

    // register writes take effect at the access edge
    if (wr_acc) begin
      case (paddr)
        `PDT_OFS_DTCTRL: begin
          next_s.dead_time_length = pwdata[`PDT_DT_LEN_LSB +: `PDT_DT_W];
          next_s.dead_time_enable = pwdata[`PDT_DT_EN_LSB +: `PDT_NCH];
        end
        `PDT_OFS_TCMD: begin
          // a software set beats the automatic clear in the same cycle
          if (pwdata[`PDT_CMD_STE_CLR]) begin
            next_s.shadow_transfer_enable = 1'b0;
          end
          if (pwdata[`PDT_CMD_STE_SET]) begin
            next_s.shadow_transfer_enable = 1'b1;
          end
        end
        `PDT_OFS_MODCTRL: begin
          next_s.main_timer_mod_enable   = pwdata[`PDT_MOD_T12_LSB +: `PDT_NOUT];
          next_s.aux_timer_mod_enable    = pwdata[`PDT_MOD_T13_LSB +: `PDT_NOUT];
          next_s.multichannel_mod_enable = pwdata[`PDT_MOD_MCM];
        end
        `PDT_OFS_PSL: begin
          next_s.psl_shadow = pwdata[`PDT_NOUT-1:0];
        end
        `PDT_OFS_TRAPEN: begin
          next_s.trap_enable = pwdata[`PDT_NOUT-1:0];
        end
        `PDT_OFS_COMPARE_STATUS_REG: begin
          next_s.act_before = pwdata[`PDT_CMP_SEL_LSB +: `PDT_NOUT];
        end
        default: begin
        end
      endcase
    end

    // read mux, sampled at the setup edge
    rd_hit = 1'b1;
    case (paddr)
      `PDT_OFS_DTCTRL: begin
        rd_val[`PDT_DT_LEN_LSB +: `PDT_DT_W] = s.dead_time_length;
        rd_val[`PDT_DT_EN_LSB +: `PDT_NCH]   = s.dead_time_enable;
        rd_val[`PDT_DT_BUSY_LSB +: `PDT_NCH] = dt_busy;
      end
      `PDT_OFS_TCMD: begin
        rd_val[`PDT_CMD_STE_RD] = s.shadow_transfer_enable;
      end
      `PDT_OFS_MODCTRL: begin
        rd_val[`PDT_MOD_T12_LSB +: `PDT_NOUT] = s.main_timer_mod_enable;
        rd_val[`PDT_MOD_T13_LSB +: `PDT_NOUT] = s.aux_timer_mod_enable;
        rd_val[`PDT_MOD_MCM]                  = s.multichannel_mod_enable;
      end
      `PDT_OFS_PSL: begin
        rd_val[`PDT_NOUT-1:0] = s.psl_work;
      end
      `PDT_OFS_TRAPEN: begin
        rd_val[`PDT_NOUT-1:0] = s.trap_enable;
      end
      `PDT_OFS_COMPARE_STATUS_REG: begin
        rd_val[`PDT_CMP_ST_LSB +: `PDT_NCH]   = channel_state_bit;
        rd_val[`PDT_CMP_SEL_LSB +: `PDT_NOUT] = s.act_before;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase

    // zero-wait slave: ready rises for the access cycle after every setup
    next_s.pready = psel & ~penable;
    if (psel && !penable) begin
      next_s.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      next_s.pslverr = ~rd_hit;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s                         <= '0;
      s.dead_time_length        <= `PDT_RST_DT_LEN;
      s.dead_time_enable        <= `PDT_RST_DT_EN;
      s.act_before              <= `PDT_RST_ACT_SEL;
      s.psl_shadow              <= `PDT_RST_PSL;
      s.psl_work                <= `PDT_RST_PSL;
      s.main_timer_mod_enable   <= `PDT_RST_MOD;
      s.aux_timer_mod_enable    <= `PDT_RST_MOD;
      s.trap_enable             <= `PDT_RST_TRAPEN;
    end else begin
      s <= next_s;
    end
  end

  assign prdata               = s.prdata;
  assign pready               = s.pready;
  assign pslverr              = s.pslverr;
  assign primary_output       = s.primary_output;
  assign complementary_output = s.complementary_output;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar c = 0; c < `PDT_NCH; c++) begin : g_chk
    chk_dt_exclusive: assert property (!(dir_sig[c] && inv_sig[c]))
      else $error("direct and inverted both active");
    chk_dt_load: assert property (dt_start[c] && !dead_time_reset_cmd |=>
      s.dt_cnt[c] == $past(s.dead_time_length) - 8'h01)
      else $error("dead-time counter did not load length");
    chk_dt_reset_cmd: assert property (dead_time_reset_cmd |=> (s.dt_cnt[c] == '0)
      && (dt_busy[c] == dt_start[c]))
      else $error("reset command left counter running");
    chk_dt_disabled: assert property (!s.dead_time_enable[c] |-> !dt_busy[c])
      else $error("disabled counter delays an edge");
    chk_dt_ignore: assert property ((s.dt_cnt[c] != '0) && s.dead_time_enable[c] && !dead_time_reset_cmd
      |=> s.dt_cnt[c] == $past(s.dt_cnt[c]) - 8'h01)
      else $error("state change restarted a running dead time");

    sequence s_dir_then_low;
      dir_sig[c] ##1 !channel_state_bit[c];
    endsequence

    sequence s_leg_armed;
      !wr_acc && s.dead_time_enable[c] && (s.dead_time_length > 8'h01);
    endsequence

    chk_dt_start: assert property (s.dead_time_enable[c] && (s.dead_time_length != '0)
      && (s.dt_cnt[c] == '0) && (channel_state_bit[c] != s.st_prev[c]) |-> dt_busy[c])
      else $error("state change did not start dead time");

    chk_dt_release: assert property ((s.dt_cnt[c] == '0) && !dt_start[c] |-> !dt_busy[c])
      else $error("dead time held past zero count");

    chk_dt_direct: assert property (dir_sig[c] |-> channel_state_bit[c] && !dt_busy[c])
      else $error("direct copy active against state or dead time");

    chk_dt_inverted: assert property (inv_sig[c] |-> !channel_state_bit[c] && !dt_busy[c])
      else $error("inverted copy active against state or dead time");

    chk_dt_one_active: assert property (!dt_busy[c] |-> dir_sig[c] != inv_sig[c])
      else $error("no copy active outside dead time");

    chk_dt_fall_pass: assert property (s_dir_then_low |-> !dir_sig[c])
      else $error("active-to-passive edge was delayed");

    chk_dt_hold_off: assert property (s_dir_then_low ##0 s_leg_armed |-> !inv_sig[c] ##1 !inv_sig[c])
      else $error("inverted copy rose without dead time");

    chk_dt_inv_pass: assert property (inv_sig[c] ##1 channel_state_bit[c] |-> !inv_sig[c])
      else $error("inverted copy stayed active after state rose");

    chk_sel_primary: assert property (cmp_sig[2*c] == (s.act_before[2*c] ? inv_sig[c] : dir_sig[c]))
      else $error("primary state selection wrong");

    chk_sel_compl: assert property (cmp_sig[2*c+1] == (s.act_before[2*c+1] ? inv_sig[c] : dir_sig[c]))
      else $error("complementary state selection wrong");

    chk_pin_primary: assert property (1'b1 |=>
      primary_output[c] == ($past(s.psl_work[2*c]) ^ $past(mod_act[2*c])))
      else $error("primary pin level wrong");

    chk_pin_compl: assert property (1'b1 |=>
      complementary_output[c] == ($past(s.psl_work[2*c+1]) ^ $past(mod_act[2*c+1])))
      else $error("complementary pin level wrong");
  end

  sequence s_no_xfer;
    !main_shadow_transfer;
  endsequence
  chk_psl_hold: assert property (s_no_xfer |=> $stable(s.psl_work))
    else $error("working passive levels moved without transfer");
  chk_psl_stopped: assert property (!timer.run |=> s.psl_work == $past(s.psl_shadow))
    else $error("stopped timer did not transfer passive levels");
  chk_trap_force: assert property (trap_state && s.trap_enable[0] |=>
    primary_output[0] == $past(s.psl_work[0]))
    else $error("trap did not force passive level");
  chk_mod_none: assert property (!s.main_timer_mod_enable[1] && !s.aux_timer_mod_enable[1]
    && !s.multichannel_mod_enable |=> complementary_output[0] == $past(s.psl_work[1]))
    else $error("unmodulated output not passive");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready did not pulse after setup");

  chk_apb_unmapped: assert property (psel && !penable && (paddr > `PDT_OFS_COMPARE_STATUS_REG) |=> pslverr && pready)
    else $error("unmapped address not refused");

  // ----------------------------------------
  // per-output modulation checks
  // ----------------------------------------
  for (genvar y = 0; y < `PDT_NOUT; y++) begin : g_out
    chk_mod_main: assert property (s.main_timer_mod_enable[y] && !cmp_sig[y] |-> !mod_act[y])
      else $error("passive compare signal did not block output");

    chk_mod_aux: assert property (s.aux_timer_mod_enable[y] && !aux_compare_signal |-> !mod_act[y])
      else $error("passive aux compare signal did not block output");

    chk_mod_pattern: assert property (s.multichannel_mod_enable && !multichannel_pattern_bit[y]
      |-> !mod_act[y])
      else $error("passive pattern bit did not block output");

    chk_mod_all: assert property ((s.main_timer_mod_enable[y] || s.aux_timer_mod_enable[y]
      || s.multichannel_mod_enable) && (!s.main_timer_mod_enable[y] || cmp_sig[y])
      && (!s.aux_timer_mod_enable[y] || aux_compare_signal)
      && (!s.multichannel_mod_enable || multichannel_pattern_bit[y])
      && !(trap_state && s.trap_enable[y]) |-> mod_act[y])
      else $error("all enabled inputs active but output passive");

    chk_mod_idle: assert property (!s.main_timer_mod_enable[y] && !s.aux_timer_mod_enable[y]
      && !s.multichannel_mod_enable |-> !mod_act[y])
      else $error("output active with no input enabled");

    chk_trap_out: assert property (trap_state && s.trap_enable[y] |-> !mod_act[y])
      else $error("trap left an enabled output active");
  end

  // ----------------------------------------
  // register and shadow checks
  // ----------------------------------------
  chk_dt_len_write: assert property (wr_acc && (paddr == `PDT_OFS_DTCTRL) |=>
    s.dead_time_length == $past(pwdata[`PDT_DT_LEN_LSB +: `PDT_DT_W]))
    else $error("dead-time length not taken from write");

  chk_psl_read: assert property (psel && !penable && !pwrite && (paddr == `PDT_OFS_PSL) |=>
    prdata == {26'h000_0000, $past(s.psl_work)})
    else $error("passive level read did not return working bits");

  chk_psl_write: assert property (wr_acc && (paddr == `PDT_OFS_PSL) |=>
    s.psl_shadow == $past(pwdata[`PDT_NOUT-1:0]))
    else $error("passive level write missed shadow bits");

  chk_xfer_period: assert property (timer.run && s.shadow_transfer_enable && timer.period_match
    && !timer.count_down |=> s.psl_work == $past(s.psl_shadow))
    else $error("period match did not transfer passive levels");

  chk_xfer_one: assert property (timer.run && s.shadow_transfer_enable && timer.one_match
    && timer.count_down |=> s.psl_work == $past(s.psl_shadow))
    else $error("one match did not transfer passive levels");

  chk_ste_clear: assert property (main_shadow_transfer && !(wr_acc && (paddr == `PDT_OFS_TCMD)
    && pwdata[`PDT_CMD_STE_SET]) |=> !s.shadow_transfer_enable)
    else $error("transfer enable not cleared by transfer");

  chk_ste_set_wins: assert property (wr_acc && (paddr == `PDT_OFS_TCMD) && pwdata[`PDT_CMD_STE_SET] |=>
    s.shadow_transfer_enable)
    else $error("software set of transfer enable lost");

endmodule

// *** tb/pdt_switch_model.sv ***
/*
  behavioural model of the external half-bridge switch drivers, one leg per channel.
  assumes a switch conducts whenever its pin differs from the off level set by software.
*/
module pdt_switch_model (
  // pins and configuration
  input  wire logic       pclk,
  input  wire logic [2:0] hi_pin,
  input  wire logic [2:0] lo_pin,
  input  wire logic [5:0] off_lvl,
  input  wire logic       watch,
  // result
  output int              n_overlap
);
  timeunit 1ns;
  timeprecision 100ps;

  initial n_overlap = 0;

  // both switches of one leg on would short the supply rail
  always @(posedge pclk) begin
    for (int c = 0; c < 3; c++) begin
      if (watch && (hi_pin[c] != off_lvl[2*c]) && (lo_pin[c] != off_lvl[2*c+1])) begin
        n_overlap++;
      end
    end
  end
endmodule

// *** tb/tb_pdt_output_path.sv ***
/*
  self-checking bench of the dead-time output path, driving apb and compare sources.
  assumes pdt_params.svh and pdt_pkg are compiled first; pclk is also the timer clock.
*/
`include "pdt_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_pdt_output_path;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, trap_state = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0]  channel_state_bit = 0, primary_output, complementary_output;
  logic [5:0]  multichannel_pattern_bit = 0, off_lvl = 0;
  logic        aux_compare_signal = 1, watch = 1, er;
  pdt_pkg::pdt_timer_s timer = '0;
  int n_errors = 0, tests_run = 0, n_overlap, n;

  always #5 pclk = ~pclk;

  pdt_output_path i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_state_bit(channel_state_bit), .timer(timer), .aux_compare_signal(aux_compare_signal),
    .multichannel_pattern_bit(multichannel_pattern_bit), .trap_state(trap_state),
    .primary_output(primary_output), .complementary_output(complementary_output));

  pdt_switch_model i_sw (.pclk(pclk), .hi_pin(primary_output), .lo_pin(complementary_output),
    .off_lvl(off_lvl), .watch(watch), .n_overlap(n_overlap));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    print_verdict();
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask

  task automatic pins(input logic [2:0] ep, input logic [2:0] ec);
    repeat (3) @(posedge pclk);
    `CHK("primary", ep, primary_output)
    `CHK("compl", ec, complementary_output)
  endtask

  // edges from the state rise until the primary pin is seen active
  task automatic dt_run(input int c, input int exp_n);
    channel_state_bit[c] <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (primary_output[c] !== 1'b1 && n < 300);
    if (n >= 300) hang();
    `CHK("dt_delay", exp_n, n)
    channel_state_bit[c] <= 1'b0;
    repeat (exp_n + 4) @(posedge pclk);
  endtask

  task automatic t_reset();
    apb(0, `PDT_OFS_DTCTRL, 0);
    `CHK("dtctrl", 32'h0000_0000, rd)
    apb(0, `PDT_OFS_COMPARE_STATUS_REG, 0);
    `CHK("compare_status_reg", 32'h0000_2A00, rd)
    apb(0, 8'h18, 0);
    `CHK("unmapped", 1'b1, er)
    $display("test reset done");
  endtask

  task automatic t_mod();
    channel_state_bit <= 3'b101;
    apb(1, `PDT_OFS_MODCTRL, 32'h0000_003F);
    pins(3'b101, 3'b010);
    apb(1, `PDT_OFS_TRAPEN, 32'h0000_0001);
    trap_state <= 1;
    pins(3'b100, 3'b010);
    trap_state <= 0;
    multichannel_pattern_bit <= 6'b11_1110;
    apb(1, `PDT_OFS_MODCTRL, 32'h0000_00BF);
    pins(3'b100, 3'b010);
    aux_compare_signal <= 0;
    apb(1, `PDT_OFS_MODCTRL, 32'h0000_3F3F);
    pins(3'b000, 3'b000);
    aux_compare_signal <= 1;
    pins(3'b101, 3'b010);
    apb(1, `PDT_OFS_COMPARE_STATUS_REG, 32'h0000_1500);
    pins(3'b010, 3'b101);
    apb(1, `PDT_OFS_COMPARE_STATUS_REG, 32'h0000_2A00);
    apb(1, `PDT_OFS_MODCTRL, 32'h0000_0000);
    pins(3'b000, 3'b000);
    apb(1, `PDT_OFS_MODCTRL, 32'h0000_003F);
    channel_state_bit <= 3'b000;
    pins(3'b000, 3'b111);
    $display("test modulation done");
  endtask

  task automatic t_dead();
    for (int c = 0; c < 3; c++) begin
      apb(1, `PDT_OFS_DTCTRL, (32'h1 << (8 + c)) | 32'h4);
      dt_run(c, 6);
    end
    apb(1, `PDT_OFS_DTCTRL, 32'h0000_0004);
    dt_run(0, 2);
    apb(1, `PDT_OFS_DTCTRL, 32'h0000_0104);
    channel_state_bit[0] <= 1'b1;
    repeat (2) @(posedge pclk);
    channel_state_bit[0] <= 1'b0;
    n = 2;
    do begin @(posedge pclk); n++; end while (complementary_output[0] !== 1'b1 && n < 50);
    `CHK("dt_ignore", 6, n)
    apb(1, `PDT_OFS_DTCTRL, 32'h0000_01C8);
    channel_state_bit[0] <= 1'b1;
    apb(1, `PDT_OFS_TCMD, 32'h0000_0001);
    @(posedge pclk);
    `CHK("dt_cmd", 1'b1, primary_output[0])
    channel_state_bit[0] <= 1'b0;
    apb(1, `PDT_OFS_TCMD, 32'h0000_0001);
    pins(3'b000, 3'b111);
    `CHK("overlap", 0, n_overlap)
    $display("test dead time done");
  endtask

  task automatic t_shadow();
    watch <= 0;
    timer <= pdt_pkg::pdt_timer_s'(4'b1000);
    apb(1, `PDT_OFS_MODCTRL, 32'h0000_0000);
    apb(1, `PDT_OFS_PSL, 32'h0000_003F);
    apb(0, `PDT_OFS_PSL, 0);
    `CHK("psl_rd", 32'h0000_0000, rd)
    apb(1, `PDT_OFS_TCMD, 32'h0000_0002);
    apb(0, `PDT_OFS_TCMD, 0);
    `CHK("ste", 32'h0000_0008, rd)
    pins(3'b000, 3'b000);
    timer <= pdt_pkg::pdt_timer_s'(4'b1010);
    @(posedge pclk);
    timer <= pdt_pkg::pdt_timer_s'(4'b1000);
    pins(3'b111, 3'b111);
    apb(0, `PDT_OFS_TCMD, 0);
    `CHK("ste_clr", 32'h0000_0000, rd)
    apb(1, `PDT_OFS_PSL, 32'h0000_0000);
    apb(1, `PDT_OFS_TCMD, 32'h0000_0002);
    timer <= pdt_pkg::pdt_timer_s'(4'b1101);
    @(posedge pclk);
    timer <= pdt_pkg::pdt_timer_s'(4'b1100);
    apb(0, `PDT_OFS_PSL, 0);
    `CHK("psl_dn", 32'h0000_0000, rd)
    $display("test shadow done");
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_mod();
    t_dead();
    t_shadow();
    print_verdict();
  end
endmodule
